// file: logic/pwt_top.sv
/*
  Polling and wakeup timer top: control registers, calibration triggers,
  wakeup counter and the actions launched on each polling event.
  Assumes all inputs, the oscillator level included, are synchronous to clk,
  and that clk is the crystal reference.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwt_map.svh"
module pwt_top
  import pwt_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // device state
  input  wire logic                   power_down,
  input  wire logic                   xo_ready,
  input  wire logic                   boot_default_pin,
  input  wire logic                   lowpower_osc_clk,
  // host register writes
  input  wire logic                   ctl_we,
  input  wire logic [2:0]             ctl_wdata,
  input  wire logic                   interval_we,
  input  wire logic [7:0]             interval_wdata,
  input  wire logic                   action_we,
  input  wire pwt_action_s            action_wdata,
  // receive flags currently held by the device
  input  wire pwt_rxflags_s           rx_flags_in,
  // register readback
  output logic [2:0]                  ctl_rd,
  output logic [7:0]                  interval_rd,
  output pwt_action_s                 action_rd,
  // wakeup results
  output logic                        irq_req,
  output logic                        wake_req,
  output logic                        rx_launch,
  output pwt_rxflags_s                rx_flags_out,
  output pwt_mode_e                   next_mode,
  output logic                        cal_busy
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  logic                      poll_timer_on;
  logic                      long_span_sel;
  logic [7:0]                wakeup_interval;
  pwt_action_s               wakeup_action;
  logic                      boot_done;
  logic                      lp_q;
  logic                      lp_rise;
  logic                      pd_q;
  logic                      auto_armed;
  logic                      auto_go;
  logic                      kick_go;
  logic                      cal_start;
  logic                      cal_run_ok;
  logic [`PWT_TRIM_W-1:0]    tick_trim_value;
  logic                      trim_busy;
  logic                      trimmed_tick;
  logic [`PWT_EXT_W-1:0]     span_pre;
  logic                      wake_tick;
  logic [7:0]                poll_count;
  logic                      shrink;
  logic                      poll_event;
  logic                      rx_event;

  // ****************************************************************
  // control registers
  // ****************************************************************
  // the strap is caught on the first edge after release, never in reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      boot_done <= 1'b0;
    else
      boot_done <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      poll_timer_on <= 1'b0;
    else if (!boot_done)
      poll_timer_on <= boot_default_pin;
    else if (ctl_we)
      poll_timer_on <= ctl_wdata[`PWT_CTL_ON];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      long_span_sel <= 1'b0;
    else if (ctl_we)
      long_span_sel <= ctl_wdata[`PWT_CTL_LONG];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wakeup_interval <= `PWT_INTERVAL_RST;
    else if (interval_we)
      wakeup_interval <= interval_wdata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wakeup_action <= pwt_action_s'(`PWT_ACTION_RST);
    else if (action_we)
      wakeup_action <= action_wdata;
  end

  // kick is never stored, so it reads back as zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_rd      <= 3'h0;
      interval_rd <= `PWT_INTERVAL_RST;
      action_rd   <= pwt_action_s'(`PWT_ACTION_RST);
    end
    else
    begin
      ctl_rd      <= {1'b0, long_span_sel, poll_timer_on};
      interval_rd <= wakeup_interval;
      action_rd   <= wakeup_action;
    end
  end

  // ****************************************************************
  // calibration triggers
  // ****************************************************************
  // gating on the old timer-on value drops a kick in the enabling write
  assign kick_go = ctl_we && ctl_wdata[`PWT_CTL_KICK] && poll_timer_on
                   && xo_ready && !power_down;
  assign auto_go    = auto_armed && xo_ready && !power_down;
  assign cal_run_ok = poll_timer_on && xo_ready && !power_down;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pd_q <= 1'b0;
    else
      pd_q <= power_down;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      auto_armed <= 1'b0;
    else if (power_down)
      auto_armed <= 1'b0;
    else if (pd_q)
      auto_armed <= 1'b1;
    else if (xo_ready)
      auto_armed <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cal_start <= 1'b0;
    else
      cal_start <= kick_go || auto_go;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cal_busy <= 1'b0;
    else
      cal_busy <= trim_busy;
  end

  // ****************************************************************
  // oscillator edge, calibration and trimmed tick
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lp_q <= 1'b0;
    else
      lp_q <= lowpower_osc_clk;
  end

  assign lp_rise = lowpower_osc_clk && !lp_q;

  pwt_trim u_trim (
    .clk        (clk),
    .rst_n      (rst_n),
    .start      (cal_start),
    .run_ok     (cal_run_ok),
    .lp_rise    (lp_rise),
    .trim_value (tick_trim_value),
    .busy       (trim_busy)
  );

  pwt_tick u_tick (
    .clk        (clk),
    .rst_n      (rst_n),
    .run        (poll_timer_on),
    .lp_rise    (lp_rise),
    .trim_value (tick_trim_value),
    .tick       (trimmed_tick)
  );

  // ****************************************************************
  // wake tick and polling counter
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      span_pre <= '0;
    else if (!poll_timer_on)
      span_pre <= '0;
    else if (trimmed_tick)
      span_pre <= span_pre + `PWT_EXT_W'(1);
  end

  assign wake_tick  = trimmed_tick && (!long_span_sel || (&span_pre));
  assign shrink     = interval_we && ((interval_wdata < poll_count)
                      || (wake_tick && interval_wdata == poll_count
                          && poll_count != wakeup_interval));
  assign poll_event = poll_timer_on && wake_tick && !shrink
                      && (poll_count == wakeup_interval);
  assign rx_event   = poll_event && (wakeup_action.mode == PM_RX);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      poll_count <= 8'h00;
    else if (!poll_timer_on)
      poll_count <= 8'h00;
    else if (shrink)
      poll_count <= 8'h00;
    else if (wake_tick)
      poll_count <= poll_event ? 8'h00 : poll_count + 8'h01;
  end

  // ****************************************************************
  // event actions
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_req <= 1'b0;
    else
      irq_req <= poll_event;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      next_mode <= PM_SLEEP;
    else if (poll_event)
      next_mode <= wakeup_action.mode;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_launch <= 1'b0;
      wake_req  <= 1'b0;
    end
    else
    begin
      rx_launch <= rx_event;
      wake_req  <= rx_event && power_down;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_flags_out <= '0;
    else if (rx_event && wakeup_action.set_flags)
    begin
      rx_flags_out.gain_flag_hi  <= wakeup_action.gain[1];
      rx_flags_out.gain_flag_lo  <= wakeup_action.gain[0];
      rx_flags_out.sub_cmd_flag  <= 1'b1;
      rx_flags_out.cmd_kind_flag <= wakeup_action.cmd_kind;
      rx_flags_out.chan_flag_hi  <= wakeup_action.wake_chan_sel[1];
      rx_flags_out.chan_flag_lo  <= wakeup_action.wake_chan_sel[0];
    end
    else if (rx_event)
      rx_flags_out <= rx_flags_in;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wake_rx;
    ##1 (rx_launch && wake_req);
  endsequence
  sequence s_flags_forced;
    ##1 (rx_flags_out.sub_cmd_flag && rx_launch);
  endsequence

  property p_irq_always;
    poll_event |=> irq_req;
  endproperty
  a_irq_always: assert property (p_irq_always) else $error("event without irq");

  property p_rx_wake;
    (rx_event && power_down) |-> s_wake_rx;
  endproperty
  a_rx_wake: assert property (p_rx_wake) else $error("no wake on rx event");

  property p_shrink_reset;
    (poll_timer_on && shrink) |=> poll_count == 8'h00;
  endproperty
  a_shrink_reset: assert property (p_shrink_reset) else $error("counter kept");

  property p_count_bound;
    poll_count <= wakeup_interval;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count past interval");

  property p_grow_keeps;
    (poll_timer_on && interval_we && !shrink && !wake_tick) |=> $stable(poll_count);
  endproperty
  a_grow_keeps: assert property (p_grow_keeps) else $error("period broken");

  property p_overwrite;
    (rx_event && wakeup_action.set_flags) |-> s_flags_forced;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("sub-command not forced");

  property p_kick_gate;
    (ctl_we && ctl_wdata[`PWT_CTL_KICK] && !poll_timer_on && !auto_go) |=> !cal_start;
  endproperty
  a_kick_gate: assert property (p_kick_gate) else $error("kick not ignored");

  property p_event_period;
    (poll_event && !long_span_sel) |=> !poll_event [*2];
  endproperty
  a_event_period: assert property (p_event_period) else $error("events too close");
endmodule : pwt_top
`default_nettype wire

// file: inc/pwt_map.svh
/*
  Named constants of the polling and wakeup timer: clock rates, calibration
  figures, control bit positions and reset values.
  Assumes the register clock is the crystal reference running at 20 MHz.
*/
`ifndef PWT_MAP_SVH
`define PWT_MAP_SVH
// ****************************************************************
// timing
// ****************************************************************
`define PWT_CLK_NS        50
`define PWT_LPOSC_NS      40000
`define PWT_TICK_NS       62500
`define PWT_TRIM_NOM      (`PWT_LPOSC_NS / `PWT_CLK_NS)
`define PWT_TICK_CYC      (`PWT_TICK_NS / `PWT_CLK_NS)
`define PWT_SETTLE_EDGES  4
// ****************************************************************
// widths, bit positions and reset values
// ****************************************************************
`define PWT_TRIM_W        12
`define PWT_ACC_W         13
`define PWT_SETTLE_W      3
`define PWT_EXT_W         4
`define PWT_CTL_ON        0
`define PWT_CTL_LONG      1
`define PWT_CTL_KICK      2
`define PWT_INTERVAL_RST  8'hff
`define PWT_ACTION_RST    8'h00
`endif

// file: inc/pwt_pkg.sv
/*
  Types of the polling and wakeup timer: poll modes, calibration states,
  the wakeup action layout and the receive flag set.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pwt_pkg;
  // ****************************************************************
  // enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    PM_SLEEP = 2'h0,
    PM_HOLD  = 2'h1,
    PM_IDLE  = 2'h3,
    PM_RX    = 2'h2
  } pwt_mode_e;

  typedef enum logic [1:0] {
    TR_IDLE   = 2'h0,
    TR_SETTLE = 2'h1,
    TR_WAIT   = 2'h3,
    TR_MEAS   = 2'h2
  } pwt_trim_e;

  // ****************************************************************
  // structures
  // ****************************************************************
  typedef struct packed {
    logic       set_flags;
    logic [1:0] wake_chan_sel;
    logic       cmd_kind;
    logic [1:0] gain;
    pwt_mode_e  mode;
  } pwt_action_s;

  typedef struct packed {
    logic gain_flag_hi;
    logic gain_flag_lo;
    logic sub_cmd_flag;
    logic cmd_kind_flag;
    logic chan_flag_hi;
    logic chan_flag_lo;
  } pwt_rxflags_s;
endpackage : pwt_pkg

// file: logic/pwt_trim.sv
/*
  Calibration engine: waits for the low-power oscillator to settle, then
  counts reference cycles over one oscillator period.
  Assumes lp_rise is a one-cycle pulse per oscillator rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwt_map.svh"
module pwt_trim
  import pwt_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // control
  input  wire logic                   start,
  input  wire logic                   run_ok,
  input  wire logic                   lp_rise,
  // result
  output logic [`PWT_TRIM_W-1:0]      trim_value,
  output logic                        busy
);
  pwt_trim_e                 state;
  logic [`PWT_SETTLE_W-1:0]  settle_cnt;
  logic [`PWT_TRIM_W-1:0]    meas;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= TR_IDLE;
    else if (!run_ok)
      state <= TR_IDLE;
    else
      unique case (state)
        TR_IDLE:   if (start) state <= TR_SETTLE;
        TR_SETTLE: if (lp_rise && settle_cnt == `PWT_SETTLE_W'(`PWT_SETTLE_EDGES - 1))
                     state <= TR_WAIT;
        TR_WAIT:   if (lp_rise) state <= TR_MEAS;
        TR_MEAS:   if (lp_rise) state <= TR_IDLE;
      endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      settle_cnt <= '0;
    else if (state != TR_SETTLE)
      settle_cnt <= '0;
    else if (lp_rise)
      settle_cnt <= settle_cnt + `PWT_SETTLE_W'(1);
  end

  // saturates so a stopped oscillator cannot wrap to a tiny period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      meas <= `PWT_TRIM_W'(1);
    else if (state != TR_MEAS)
      meas <= `PWT_TRIM_W'(1);
    else if (meas != '1)
      meas <= meas + `PWT_TRIM_W'(1);
  end

  // only a full measurement replaces the value in use
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trim_value <= `PWT_TRIM_W'(`PWT_TRIM_NOM);
    else if (run_ok && state == TR_MEAS && lp_rise)
      trim_value <= meas;
  end

  assign busy = (state != TR_IDLE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_trim_coherent;
    $changed(trim_value) |-> $past(state == TR_MEAS && lp_rise && run_ok);
  endproperty
  a_trim_coherent: assert property (p_trim_coherent) else $error("trim changed mid-run");
  property p_abort_idle;
    !run_ok |=> state == TR_IDLE;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("calibration not aborted");
  property p_settle_first;
    (state == TR_IDLE && start && run_ok) |=> state == TR_SETTLE;
  endproperty
  a_settle_first: assert property (p_settle_first) else $error("settle skipped");
endmodule : pwt_trim
`default_nettype wire

// file: logic/pwt_tick.sv
/*
  Modulo counter that turns low-power oscillator edges into trimmed ticks.
  Assumes trim_value holds reference cycles per oscillator period.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwt_map.svh"
module pwt_tick
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // inputs
  input  wire logic                   run,
  input  wire logic                   lp_rise,
  input  wire logic [`PWT_TRIM_W-1:0] trim_value,
  // output
  output logic                        tick
);
  localparam logic [`PWT_ACC_W-1:0] TICK_CYC = `PWT_ACC_W'(`PWT_TICK_CYC);
  logic [`PWT_ACC_W-1:0] acc;
  logic [`PWT_ACC_W-1:0] sum;

  assign sum = acc + `PWT_ACC_W'(trim_value);

  // remainder carried so the long-run rate stays exact
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acc <= '0;
    else if (!run)
      acc <= '0;
    else if (lp_rise)
      acc <= (sum >= TICK_CYC) ? sum - TICK_CYC : sum;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick <= 1'b0;
    else
      tick <= run && lp_rise && (sum >= TICK_CYC);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_acc_bound;
    acc < TICK_CYC;
  endproperty
  a_acc_bound: assert property (p_acc_bound) else $error("accumulator past modulus");
  property p_tick_cause;
    tick |-> $past(lp_rise && run);
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("tick without edge");
endmodule : pwt_tick
`default_nettype wire

// file: tb/pwt_top_tb_top.sv
/*
  Self-checking bench for the polling and wakeup timer top: reset values,
  calibration triggers, event timing, poll actions and interval rewrites.
  Assumes a 20 MHz reference and a bench-made 45 us low-power oscillator.
*/
`timescale 1ns/1ps
`default_nettype none
module pwt_top_tb_top
  import pwt_pkg::*;
();
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         power_down = 1'b0;
  logic         xo_ready = 1'b1;
  logic         boot_default_pin = 1'b1;
  logic         lowpower_osc_clk = 1'b0;
  logic         ctl_we = 1'b0;
  logic [2:0]   ctl_wdata = 3'h0;
  logic         interval_we = 1'b0;
  logic [7:0]   interval_wdata = 8'h00;
  logic         action_we = 1'b0;
  pwt_action_s  action_wdata = '0;
  pwt_rxflags_s rx_flags_in = 6'h12;
  logic [2:0]   ctl_rd;
  logic [7:0]   interval_rd;
  pwt_action_s  action_rd;
  logic         irq_req;
  logic         wake_req;
  logic         rx_launch;
  pwt_rxflags_s rx_flags_out;
  pwt_mode_e    next_mode;
  logic         cal_busy;
  int           n_fail = 0;
  int           n_checks = 0;
  int           osc_cnt = 0;
  int           c;
  pwt_mode_e    modes [4] = '{PM_SLEEP, PM_HOLD, PM_IDLE, PM_RX};

  // no port reaches the trim value; calibration shows as cal_busy and in the irq_req spacing
  pwt_top u_dut (
    .clk(clk), .rst_n(rst_n), .power_down(power_down), .xo_ready(xo_ready),
    .boot_default_pin(boot_default_pin), .lowpower_osc_clk(lowpower_osc_clk),
    .ctl_we(ctl_we), .ctl_wdata(ctl_wdata), .interval_we(interval_we),
    .interval_wdata(interval_wdata), .action_we(action_we),
    .action_wdata(action_wdata), .rx_flags_in(rx_flags_in), .ctl_rd(ctl_rd),
    .interval_rd(interval_rd), .action_rd(action_rd), .irq_req(irq_req),
    .wake_req(wake_req), .rx_launch(rx_launch), .rx_flags_out(rx_flags_out),
    .next_mode(next_mode), .cal_busy(cal_busy)
  );

  initial
  begin
    forever #25 clk = ~clk;
  end

  // low-power oscillator: 900 reference cycles, off nominal so a trim shows in the tick rate
  always @(posedge clk)
  begin
    if (osc_cnt == 449)
    begin
      osc_cnt <= 0;
      lowpower_osc_clk <= ~lowpower_osc_clk;
    end
    else
      osc_cnt <= osc_cnt + 1;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_span(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_span

  // sel 0 control, 1 wakeup_interval, 2 wakeup_action
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk);
    ctl_we <= (sel == 0);
    interval_we <= (sel == 1);
    action_we <= (sel == 2);
    ctl_wdata <= d[2:0];
    interval_wdata <= d;
    action_wdata <= pwt_action_s'(d);
    @(posedge clk);
    ctl_we <= 1'b0;
    interval_we <= 1'b0;
    action_we <= 1'b0;
  endtask : wr

  task automatic wait_irq(input int lim, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk);
      #1;
      cyc++;
    end
    while (irq_req !== 1'b1 && cyc < lim);
    chk("irq_req", 8'h01, {7'h0, irq_req});
  endtask : wait_irq

  task automatic wait_busy(input logic lvl, input int lim);
    int i;
    i = 0;
    while (cal_busy !== lvl && i < lim)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("cal_busy", {7'h0, lvl}, {7'h0, cal_busy});
  endtask : wait_busy

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    repeat (3) @(posedge clk);
    #1;
    chk("ctl_rd", 8'h01, {5'h0, ctl_rd});
    chk("interval_rd", 8'hff, interval_rd);
    chk("action_rd", 8'h00, action_rd);
    chk("next_mode", 8'h00, {6'h0, next_mode});
  endtask : t_reset

  task automatic t_kick();
    logic seen;
    wr(0, 8'h07);
    repeat (2) @(posedge clk);
    #1;
    chk("ctl_rd", 8'h03, {5'h0, ctl_rd});
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 8000);
    // no crystal: the kick must be dropped
    @(posedge clk);
    xo_ready <= 1'b0;
    wr(0, 8'h05);
    seen = 1'b0;
    repeat (10)
    begin
      @(posedge clk);
      #1;
      seen = seen | cal_busy;
    end
    chk("cal_busy", 8'h00, {7'h0, seen});
    // timer off: the kick must be dropped as well
    @(posedge clk);
    xo_ready <= 1'b1;
    wr(0, 8'h00);
    wr(0, 8'h04);
    seen = 1'b0;
    repeat (10)
    begin
      @(posedge clk);
      #1;
      seen = seen | cal_busy;
    end
    chk("cal_busy", 8'h00, {7'h0, seen});
  endtask : t_kick

  task automatic t_period();
    wr(0, 8'h01);
    wr(2, 8'h01);
    wr(1, 8'h01);
    @(posedge clk);
    #1;
    chk("interval_rd", 8'h01, interval_rd);
    chk("action_rd", 8'h01, action_rd);
    wait_irq(4000, c);
    wait_irq(4000, c);
    // two trimmed ticks land two or three oscillator edges apart
    chk_span("period", 1800, 2700, c);
  endtask : t_period

  task automatic t_modes();
    wr(1, 8'h00);
    foreach (modes[i])
    begin
      wr(2, {6'h0, modes[i]});
      wait_irq(2000, c);
      chk("next_mode", {6'h0, modes[i]}, {6'h0, next_mode});
      chk("rx_launch", {7'h0, modes[i] == PM_RX}, {7'h0, rx_launch});
      chk("wake_req", 8'h00, {7'h0, wake_req});
    end
    chk("rx_flags_out", 8'h12, {2'h0, rx_flags_out});
  endtask : t_modes

  task automatic t_action();
    @(posedge clk);
    power_down <= 1'b1;
    wr(2, 8'hba);
    wait_irq(2000, c);
    chk("wake_req", 8'h01, {7'h0, wake_req});
    chk("rx_launch", 8'h01, {7'h0, rx_launch});
    chk("rx_flags_out", 8'h2d, {2'h0, rx_flags_out});
    @(posedge clk);
    power_down <= 1'b0;
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 8000);
  endtask : t_action

  task automatic t_shrink();
    wr(2, 8'h01);
    wr(1, 8'hff);
    repeat (3000) @(posedge clk);
    // count is past zero now, so only a reset makes the next tick fire
    wr(1, 8'h00);
    wait_irq(2000, c);
  endtask : t_shrink

  task automatic t_long();
    wr(0, 8'h03);
    wait_irq(22000, c);
    wait_irq(22000, c);
    chk_span("long period", 19000, 21000, c);
  endtask : t_long

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_kick();
    t_period();
    t_modes();
    t_action();
    t_shrink();
    t_long();
    stop_test();
  end

  // whole run needs some 65k cycles; 90k at 50 ns is the cut-off
  initial
  begin
    #4500000;
    n_fail++;
    stop_test();
  end
endmodule : pwt_top_tb_top
`default_nettype wire
